//--- core/osv_map.svh
// Purpose: register map, field positions and timing constants for the oscillator supervisor
// Assumes: 32-bit AXI4-Lite, one register per aligned word, byte address is four times index
// Notes: printed offsets are kept as indices
//
// Behaviour
// - Wake-up interrupt runs on main clock
// - Power-down stops both oscillators, wake restarts them
// - Wait stabilization delay before wake interrupt
// - Supervisor always enabled, no disable bit
// - Divide reference by ten, flag slower main
// - Failure switches system clock to reference
// - Failure asserts internal reset
// - Supervisor reset keeps timer flag, sets fail flag
// - Recovery runs final reset phase on reference
// - Return clock to main, then release reset
// - Chip stays reset while other requests remain
// - Fail flag software writable; external reset clears flags
// - Wake needs enable bit and low pin
// - Source select picks monitored wake pin
// - No reset during wake-up oscillator start
// - Raise wake interrupt after start-up completes
// - Power-on treats main oscillator as failed
// - Select zero is interrupt pin, reset default
// - Enable bit seven, select bit four
`ifndef OSV_MAP_SVH
`define OSV_MAP_SVH

`define OSV_IDX_STATUS 8'hA9
`define OSV_IDX_PWAKE 8'h88
`define OSV_IDX_SUPV 8'hC0
`define OSV_ADDR_W 10
`define OSV_BIT_FAIL 7
`define OSV_BIT_TRST 6
`define OSV_BIT_WEN 7
`define OSV_BIT_WSEL 4
`define OSV_STATUS_RST 8'h00
`define OSV_REF_DIV 4'hA
`define OSV_CLK_NS 5
`define OSV_STAB_NS 1000000
`define OSV_RESP_OK 2'h0
`define OSV_RESP_ERR 2'h2

`endif

//--- core/osv_pkg.sv
// Purpose: types for the oscillator supervisor
// Assumes: one 200 MHz clock
// Notes: state codes are one-hot
`include "osv_map.svh"

package osv_pkg;

  typedef enum logic [6:0] {
    OSV_FAIL = 7'h01,
    OSV_FINAL = 7'h02,
    OSV_REL = 7'h04,
    OSV_RUN = 7'h08,
    OSV_PD = 7'h10,
    OSV_WAKE = 7'h20,
    OSV_WSTAB = 7'h40
  } osv_state_t;

  typedef struct packed {
    logic clk_sel_rc;
    logic osc_reset;
    logic chip_reset;
    logic osc_run;
    logic wake_irq;
    logic wdt_stop;
  } osv_out_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic aw_v;
    logic w_v;
    logic [`OSV_ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
  } osv_bus_t;

  typedef struct packed {
    osv_state_t st;
    logic [23:0] cnt;
    logic [3:0] rc_div;
    logic main_seen;
    logic main_slow;
    logic [2:0] rc_sh;
    logic [2:0] main_sh;
    logic [1:0] wk0_sh;
    logic [1:0] wk1_sh;
    logic [7:0] status;
    logic wake_en;
    logic wake_sel;
    osv_out_t o;
    osv_bus_t b;
  } osv_regs_t;

endpackage

//--- core/osv_top.sv
// Purpose: oscillator supervisor with clock switch-over, reset and power-down wake control
// Assumes: both oscillators toggle below half of aclk; aclk keeps running in power-down
// Notes: registers over AXI4-Lite; only the low byte of each word is used
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "osv_map.svh"

module osv_top
  import osv_pkg::*;
#(
  parameter logic [23:0] STAB_CYC = 24'(`OSV_STAB_NS / `OSV_CLK_NS)
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic main_osc_in, // main oscillator output, asynchronous
  input wire logic rc_osc_in, // reference oscillator output, asynchronous
  input wire logic wake_pin_ext_irq, // wake pin, low active, asynchronous
  input wire logic wake_pin_serial_rx, // wake pin, low active, asynchronous
  input wire logic pd_enter, // one-cycle power-down entry request
  input wire logic ext_reset_req, // external reset request, level
  input wire logic wdt_reset_req, // software watchdog reset request, level
  output logic clk_sel_rc, // system clock taken from reference oscillator
  output logic osc_reset, // supervisor reset request
  output logic chip_reset, // combined chip reset
  output logic osc_run, // oscillators enabled
  output logic wake_irq, // one-cycle wake-up interrupt request
  output logic wdt_stop, // software watchdog held stopped
  input wire logic [`OSV_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`OSV_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read response valid
  input wire logic s_axi_rready // read response ready
);

  localparam logic [`OSV_ADDR_W-1:0] ADDR_STATUS = {`OSV_IDX_STATUS, 2'h0};
  localparam logic [`OSV_ADDR_W-1:0] ADDR_PWAKE = {`OSV_IDX_PWAKE, 2'h0};
  localparam logic [`OSV_ADDR_W-1:0] ADDR_SUPV = {`OSV_IDX_SUPV, 2'h0};

  osv_regs_t r_reg;
  osv_regs_t r_next;

  logic rc_edge;
  logic main_edge;
  logic wake_low;
  logic do_write;
  logic [7:0] rd_val;
  logic rd_hit;

  assign rc_edge = r_reg.rc_sh[1] & ~r_reg.rc_sh[2];
  assign main_edge = r_reg.main_sh[1] & ~r_reg.main_sh[2];
  // Only the second stage of each pin synchroniser is read
  assign wake_low = r_reg.wake_sel ? ~r_reg.wk1_sh[1] : ~r_reg.wk0_sh[1];
  assign do_write = r_reg.b.aw_v & r_reg.b.w_v & ~r_reg.b.bvalid;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (s_axi_araddr)
      ADDR_STATUS: rd_val = r_reg.status;
      ADDR_PWAKE: begin
        rd_val[`OSV_BIT_WEN] = r_reg.wake_en;
        rd_val[`OSV_BIT_WSEL] = r_reg.wake_sel;
      end
      ADDR_SUPV: rd_val = {1'b0, r_reg.st};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.o.wake_irq = 1'b0;

    r_next.rc_sh = {r_reg.rc_sh[1:0], rc_osc_in};
    r_next.main_sh = {r_reg.main_sh[1:0], main_osc_in};
    r_next.wk0_sh = {r_reg.wk0_sh[0], wake_pin_ext_irq};
    r_next.wk1_sh = {r_reg.wk1_sh[0], wake_pin_serial_rx};

    // Frequency compare: one window is ten reference edges; no main edge means too slow
    if (r_reg.st == OSV_PD) begin
      r_next.rc_div = 4'h0;
      r_next.main_seen = 1'b0;
      r_next.main_slow = 1'b1;
    end else begin
      if (main_edge) begin
        r_next.main_seen = 1'b1;
      end
      if (rc_edge) begin
        if (r_reg.rc_div == `OSV_REF_DIV - 4'h1) begin
          r_next.rc_div = 4'h0;
          r_next.main_slow = ~(r_reg.main_seen | main_edge);
          r_next.main_seen = 1'b0;
        end else begin
          r_next.rc_div = r_reg.rc_div + 4'h1;
        end
      end
    end

    // No enable bit exists: monitoring runs in every state but power-down
    case (r_reg.st)
      OSV_RUN: begin
        if (r_reg.main_slow) begin
          r_next.st = OSV_FAIL;
        end else if (pd_enter) begin
          r_next.st = OSV_PD;
        end
      end
      OSV_FAIL: begin
        r_next.cnt = 24'h0;
        if (!r_reg.main_slow) begin
          r_next.st = OSV_FINAL;
        end
      end
      OSV_FINAL: begin
        r_next.cnt = r_reg.cnt + 24'h1;
        if (r_reg.main_slow) begin
          r_next.st = OSV_FAIL;
        end else if (r_reg.cnt >= STAB_CYC - 24'h1) begin
          r_next.st = OSV_REL;
        end
      end
      OSV_REL: begin
        r_next.st = OSV_RUN;
      end
      OSV_PD: begin
        if (r_reg.wake_en && wake_low) begin
          r_next.st = OSV_WAKE;
        end
      end
      OSV_WAKE: begin
        r_next.cnt = 24'h0;
        if (!r_reg.main_slow) begin
          r_next.st = OSV_WSTAB;
        end
      end
      OSV_WSTAB: begin
        r_next.cnt = r_reg.cnt + 24'h1;
        if (r_reg.main_slow) begin
          r_next.st = OSV_WAKE;
        end else if (r_reg.cnt >= STAB_CYC - 24'h1) begin
          r_next.st = OSV_RUN;
          r_next.o.wake_irq = 1'b1;
        end
      end
      default: begin
        r_next.st = OSV_FAIL;
      end
    endcase

    // Outputs follow the next state so they stand in step with the state register
    r_next.o.clk_sel_rc = (r_next.st == OSV_FAIL) || (r_next.st == OSV_FINAL)
      || (r_next.st == OSV_WAKE) || (r_next.st == OSV_WSTAB);
    r_next.o.osc_reset = (r_next.st == OSV_FAIL) || (r_next.st == OSV_FINAL)
      || (r_next.st == OSV_REL);
    r_next.o.osc_run = (r_next.st != OSV_PD);
    r_next.o.wdt_stop = r_next.o.osc_reset;
    r_next.o.chip_reset = r_next.o.osc_reset | ext_reset_req | wdt_reset_req;

    // Register bus: address and data are taken in either order, answered together
    if (s_axi_awvalid && r_reg.b.awready) begin
      r_next.b.aw_v = 1'b1;
      r_next.b.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.b.wready) begin
      r_next.b.w_v = 1'b1;
      r_next.b.w_data = s_axi_wdata[7:0];
      r_next.b.w_strb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      r_next.b.aw_v = 1'b0;
      r_next.b.w_v = 1'b0;
      r_next.b.bvalid = 1'b1;
      r_next.b.bresp = `OSV_RESP_OK;
      case (r_reg.b.aw_addr)
        ADDR_STATUS: begin
          if (r_reg.b.w_strb0) begin
            r_next.status = r_reg.b.w_data;
          end
        end
        ADDR_PWAKE: begin
          if (r_reg.b.w_strb0) begin
            r_next.wake_en = r_reg.b.w_data[`OSV_BIT_WEN];
            r_next.wake_sel = r_reg.b.w_data[`OSV_BIT_WSEL];
          end
        end
        ADDR_SUPV: begin
        end
        default: r_next.b.bresp = `OSV_RESP_ERR;
      endcase
    end
    if (r_reg.b.bvalid && s_axi_bready) begin
      r_next.b.bvalid = 1'b0;
    end
    r_next.b.awready = ~r_next.b.aw_v & ~r_next.b.bvalid;
    r_next.b.wready = ~r_next.b.w_v & ~r_next.b.bvalid;

    if (s_axi_arvalid && r_reg.b.arready) begin
      r_next.b.arready = 1'b0;
      r_next.b.rvalid = 1'b1;
      r_next.b.rdata = rd_val;
      r_next.b.rresp = rd_hit ? `OSV_RESP_OK : `OSV_RESP_ERR;
    end else if (r_reg.b.rvalid && s_axi_rready) begin
      r_next.b.rvalid = 1'b0;
      r_next.b.arready = 1'b1;
    end

    // Chip reset returns control bits to their defaults; flags have their own clears
    if (r_reg.o.chip_reset) begin
      r_next.wake_en = 1'b0;
      r_next.wake_sel = 1'b0;
      r_next.status[5:0] = 6'(`OSV_STATUS_RST);
    end
    if (ext_reset_req) begin
      r_next.status[`OSV_BIT_FAIL] = 1'b0;
      r_next.status[`OSV_BIT_TRST] = 1'b0;
    end
    // Hardware sets come last so an event is never lost to a clear
    if (wdt_reset_req) begin
      r_next.status[`OSV_BIT_TRST] = 1'b1;
    end
    if (r_reg.st == OSV_FAIL) begin
      r_next.status[`OSV_BIT_FAIL] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.st <= OSV_FAIL;
      r_reg.main_slow <= 1'b1;
      // Wake pins idle high; a cleared stage would read as a wake request
      r_reg.wk0_sh <= '1;
      r_reg.wk1_sh <= '1;
      r_reg.o.clk_sel_rc <= 1'b1;
      r_reg.o.osc_reset <= 1'b1;
      r_reg.o.chip_reset <= 1'b1;
      r_reg.o.osc_run <= 1'b1;
      r_reg.o.wdt_stop <= 1'b1;
      r_reg.status <= `OSV_STATUS_RST;
      r_reg.b.awready <= 1'b1;
      r_reg.b.wready <= 1'b1;
      r_reg.b.arready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign clk_sel_rc = r_reg.o.clk_sel_rc;
  assign osc_reset = r_reg.o.osc_reset;
  assign chip_reset = r_reg.o.chip_reset;
  assign osc_run = r_reg.o.osc_run;
  assign wake_irq = r_reg.o.wake_irq;
  assign wdt_stop = r_reg.o.wdt_stop;
  assign s_axi_awready = r_reg.b.awready;
  assign s_axi_wready = r_reg.b.wready;
  assign s_axi_bvalid = r_reg.b.bvalid;
  assign s_axi_bresp = r_reg.b.bresp;
  assign s_axi_arready = r_reg.b.arready;
  assign s_axi_rvalid = r_reg.b.rvalid;
  assign s_axi_rresp = r_reg.b.rresp;
  assign s_axi_rdata = {24'h0, r_reg.b.rdata};

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pd_osc_stop: assert property ((r_reg.st == OSV_PD) |-> !osc_run)
    else $error("oscillators run in power-down");
  a_fail_clk_rc: assert property ((r_reg.st == OSV_FAIL) |-> clk_sel_rc && osc_reset)
    else $error("failure without reference clock and reset");
  a_slow_to_fail: assert property ((r_reg.st == OSV_RUN) && r_reg.main_slow
    |=> (r_reg.st == OSV_FAIL) && osc_reset && wdt_stop)
    else $error("slow main oscillator not caught");
  a_final_hold: assert property ((r_reg.st == OSV_FINAL) |-> clk_sel_rc && chip_reset)
    else $error("final phase left reset or reference clock");
  a_release_order: assert property ((r_reg.st == OSV_REL)
    |-> !clk_sel_rc && osc_reset ##1 !osc_reset)
    else $error("clock not back before reset release");
  a_wake_no_reset: assert property ((r_reg.st == OSV_WAKE) || (r_reg.st == OSV_WSTAB)
    |-> !osc_reset && osc_run)
    else $error("reset during wake-up start");
  a_irq_main_clk: assert property (wake_irq
    |-> !clk_sel_rc && $past(r_reg.st == OSV_WSTAB))
    else $error("wake interrupt on wrong clock");
  a_other_reset: assert property (ext_reset_req || wdt_reset_req |=> chip_reset)
    else $error("remaining reset request dropped");
  a_fail_flag_set: assert property ((r_reg.st == OSV_FAIL)
    |=> r_reg.status[`OSV_BIT_FAIL])
    else $error("failure flag not set");
  a_ext_clear: assert property (ext_reset_req && !wdt_reset_req
    && (r_reg.st == OSV_RUN) |=> r_reg.status[`OSV_BIT_FAIL:`OSV_BIT_TRST] == 2'h0)
    else $error("external reset left status flags");
  a_wake_gate: assert property ((r_reg.st == OSV_PD) && !r_reg.wake_en
    |=> r_reg.st == OSV_PD)
    else $error("wake without enable");

  // Supervisor reset leaves the timer flag alone but stops the watchdog
  a_fail_outputs: assert property ((r_reg.st == OSV_FAIL)
    |-> wdt_stop && chip_reset)
    else $error("failure reset does not stop the watchdog");
  a_trst_kept: assert property ((r_reg.st == OSV_FAIL) && !ext_reset_req
    && !wdt_reset_req && !do_write
    |=> $stable(r_reg.status[`OSV_BIT_TRST]))
    else $error("supervisor reset changed the timer flag");
  a_final_len: assert property ((r_reg.st == OSV_REL)
    |-> $past(r_reg.st == OSV_FINAL) && ($past(r_reg.cnt) >= STAB_CYC - 24'h1))
    else $error("final reset phase too short");
  a_final_fallback: assert property ((r_reg.st == OSV_FINAL) && r_reg.main_slow
    |=> (r_reg.st == OSV_FAIL) && clk_sel_rc)
    else $error("relapse in final phase not caught");
  a_run_outputs: assert property ((r_reg.st == OSV_RUN)
    |-> !clk_sel_rc && !osc_reset && !wdt_stop)
    else $error("run state on reference clock or in reset");
  a_chip_release: assert property ((r_reg.st == OSV_RUN) && !r_reg.main_slow
    && !ext_reset_req && !wdt_reset_req |=> !chip_reset)
    else $error("chip reset held without a request");
  a_div_range: assert property (r_reg.rc_div < `OSV_REF_DIV)
    else $error("reference divider out of range");
  a_pd_frozen: assert property ((r_reg.st == OSV_PD)
    |=> r_reg.main_slow && (r_reg.rc_div == 4'h0))
    else $error("monitor ran in power-down");

  // Wake path: enable, source select and the start-up wait
  a_wake_on_pin: assert property ((r_reg.st == OSV_PD) && r_reg.wake_en && wake_low
    |=> (r_reg.st == OSV_WAKE) && osc_run && clk_sel_rc)
    else $error("enabled wake request ignored");
  a_src_ext: assert property ((r_reg.st == OSV_PD) && !r_reg.wake_sel
    && r_reg.wk0_sh[1] |=> r_reg.st == OSV_PD)
    else $error("unselected wake pin woke the device");
  a_src_serial: assert property ((r_reg.st == OSV_PD) && r_reg.wake_sel
    && r_reg.wk1_sh[1] |=> r_reg.st == OSV_PD)
    else $error("unselected wake pin woke the device");
  a_pd_entry: assert property ((r_reg.st == OSV_RUN) && !r_reg.main_slow && pd_enter
    |=> (r_reg.st == OSV_PD) && !osc_run)
    else $error("power-down entry missed");
  a_wake_retry: assert property ((r_reg.st == OSV_WSTAB) && r_reg.main_slow
    |=> (r_reg.st == OSV_WAKE) && !osc_reset)
    else $error("wake relapse caused a reset");
  a_irq_pulse: assert property (wake_irq |=> !wake_irq)
    else $error("wake interrupt longer than one cycle");
  a_stab_wait: assert property (wake_irq
    |-> $past(r_reg.cnt) >= STAB_CYC - 24'h1)
    else $error("wake interrupt before stabilization delay");
  a_sel_default: assert property (chip_reset
    |=> !r_reg.wake_sel && !r_reg.wake_en)
    else $error("reset left wake control set");

  // Register answers hold until taken; software can write the whole status byte
  a_stat_write: assert property (do_write && (r_reg.b.aw_addr == ADDR_STATUS)
    && r_reg.b.w_strb0 && (r_reg.st != OSV_FAIL) && !chip_reset
    && !ext_reset_req && !wdt_reset_req |=> r_reg.status == $past(r_reg.b.w_data))
    else $error("status write not taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before taken");

  c_fail_recover: cover property ((r_reg.st == OSV_REL) ##1 (r_reg.st == OSV_RUN));
  c_wake_irq: cover property (wake_irq);
  c_pd_entry: cover property ((r_reg.st == OSV_RUN) ##1 (r_reg.st == OSV_PD));
  c_write_resp: cover property (s_axi_bvalid && s_axi_bready);
  c_fail_entry: cover property ((r_reg.st == OSV_RUN) ##1 (r_reg.st == OSV_FAIL));

endmodule

//--- test/osv_osc_model.sv
// Purpose: behavioural main and reference oscillators for the supervisor bench
// Assumes: reference 25 MHz, main 50 MHz while healthy
// Notes: both waveforms stand still while the oscillators are disabled
`timescale 1ns/1ps

module osv_osc_model (
  input wire logic run, // oscillators enabled by the supervisor
  input wire logic main_ok, // main oscillator healthy
  output logic main_osc, // main oscillator waveform
  output logic rc_osc // reference oscillator waveform
);
  initial begin
    main_osc = 1'b0;
    rc_osc = 1'b0;
  end
  // Both stop in power-down and resume on wake
  always #20 if (run) rc_osc = ~rc_osc;
  // Not running at power-on until main_ok is raised
  always #10 if (run && main_ok) main_osc = ~main_osc;
endmodule

//--- test/tb_top.sv
// Purpose: self-checking bench for the oscillator supervisor
// Assumes: short stabilisation count of 20 cycles
// Notes: register cases run from a table, sequences by hand before and after it
`timescale 1ns/1ps
`include "osv_map.svh"

module tb_top;
  import osv_pkg::*;
  localparam int STAB = 20;
  localparam logic [9:0] A_ST = {`OSV_IDX_STATUS, 2'b00};
  localparam logic [9:0] A_PW = {`OSV_IDX_PWAKE, 2'b00};
  localparam logic [9:0] A_SV = {`OSV_IDX_SUPV, 2'b00};
  typedef struct packed {
    logic wr;
    logic [9:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [1:0] r;
  } osv_row_t;
  osv_row_t rows [7] = '{
    '{1'b0, A_ST, 8'h00, 8'h80, 2'h0}, '{1'b1, A_ST, 8'h00, 8'h00, 2'h0},
    '{1'b1, A_ST, 8'hC5, 8'hC5, 2'h0}, '{1'b1, A_PW, 8'hFF, 8'h90, 2'h0},
    '{1'b1, A_PW, 8'h00, 8'h00, 2'h0}, '{1'b1, A_SV, 8'hFF, 8'h08, 2'h0},
    '{1'b1, 10'h3FC, 8'h55, 8'h00, 2'h2}};
  logic aclk = 1'b0, aresetn = 1'b0, main_ok = 1'b0, main_osc, rc_osc;
  logic wk0 = 1'b1, wk1 = 1'b1, pd_enter = 1'b0, ext_rq = 1'b0, wdt_rq = 1'b0;
  logic clk_sel_rc, osc_reset, chip_reset, osc_run, wake_irq, wdt_stop, in_wake = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int mismatches = 0, comparisons = 0, n;

  always #2.5 aclk = ~aclk;
  osv_osc_model i_osc (.run(osc_run), .main_ok(main_ok), .main_osc(main_osc), .rc_osc(rc_osc));
  osv_top #(.STAB_CYC(24'd20)) i_dut (.aclk(aclk), .aresetn(aresetn), .main_osc_in(main_osc),
    .rc_osc_in(rc_osc), .wake_pin_ext_irq(wk0), .wake_pin_serial_rx(wk1), .pd_enter(pd_enter),
    .ext_reset_req(ext_rq), .wdt_reset_req(wdt_rq), .clk_sel_rc(clk_sel_rc),
    .osc_reset(osc_reset), .chip_reset(chip_reset), .osc_run(osc_run), .wake_irq(wake_irq),
    .wdt_stop(wdt_stop), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input string nm);
    case (nm)
      "osc_reset": return osc_reset;
      "osc_run": return osc_run;
      "wake_irq": return wake_irq;
      "clk_sel_rc": return clk_sel_rc;
      default: return chip_reset;
    endcase
  endfunction
  // Bounded wait for an output level; n returns the cycles spent
  task automatic wt(input string nm, input logic v, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (pick(nm) !== v && n < 5000);
    chk(nm, v, pick(nm));
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pd_pulse();
    @(posedge aclk) pd_enter <= 1'b1;
    @(posedge aclk) pd_enter <= 1'b0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // No supervisor reset may appear while waking from power-down
  always @(posedge aclk) if (in_wake && osc_reset === 1'b1) begin
    mismatches++;
    $display("wrong value osc_reset expected 0 seen 1");
  end
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wt("osc_reset", 1'b1, n);
    chk("clk_sel_rc", 1, clk_sel_rc);
    rd(A_PW, d, r);
    chk("wake_ctl", 0, d);
    main_ok <= 1'b1;
    wt("clk_sel_rc", 1'b0, n);
    chk("final_len", 1, n >= STAB);
    chk("osc_reset", 1, osc_reset);
    wt("osc_reset", 1'b0, n);
    chk("release_gap", 1, n);
    for (int i = 0; i < 7; i++) begin
      if (rows[i].wr) wr(rows[i].a, {24'h0, rows[i].d}, r);
      if (rows[i].wr) chk("bresp", rows[i].r, r);
      rd(rows[i].a, d, r);
      chk("rresp", rows[i].r, r);
      if (rows[i].r == 2'h0) chk("rdata", rows[i].e, d);
    end
    @(posedge aclk) ext_rq <= 1'b1;
    wt("chip_reset", 1'b1, n);
    @(posedge aclk) ext_rq <= 1'b0;
    rd(A_ST, d, r);
    chk("status", 0, d);
    main_ok <= 1'b0;
    wt("osc_reset", 1'b1, n);
    chk("clk_sel_rc", 1, clk_sel_rc);
    chk("wdt_stop", 1, wdt_stop);
    @(posedge aclk) wdt_rq <= 1'b1;
    main_ok <= 1'b1;
    wt("osc_reset", 1'b0, n);
    repeat (3) @(posedge aclk);
    chk("chip_reset", 1, chip_reset);
    wdt_rq <= 1'b0;
    wt("chip_reset", 1'b0, n);
    rd(A_ST, d, r);
    chk("status", 8'hC0, d);
    wr(A_PW, 32'h90, r);
    pd_pulse();
    wt("osc_run", 1'b0, n);
    @(posedge aclk) wk0 <= 1'b0;
    repeat (30) @(posedge aclk);
    chk("osc_run", 0, osc_run);
    wk0 <= 1'b1;
    wk1 <= 1'b0;
    in_wake <= 1'b1;
    wt("osc_run", 1'b1, n);
    wt("wake_irq", 1'b1, n);
    chk("wake_wait", 1, n >= STAB);
    chk("clk_sel_rc", 0, clk_sel_rc);
    @(posedge aclk) wk1 <= 1'b1;
    @(posedge aclk);
    #1;
    chk("wake_irq", 0, wake_irq);
    in_wake <= 1'b0;
    wr(A_PW, 32'h10, r);
    pd_pulse();
    wk1 <= 1'b0;
    repeat (30) @(posedge aclk);
    chk("osc_run", 0, osc_run);
    wk1 <= 1'b1;
    wr(A_PW, 32'h80, r);
    chk("bresp", 0, r);
    repeat (30) @(posedge aclk);
    chk("osc_run", 0, osc_run);
    wk0 <= 1'b0;
    in_wake <= 1'b1;
    wt("osc_run", 1'b1, n);
    wt("wake_irq", 1'b1, n);
    chk("clk_sel_rc", 0, clk_sel_rc);
    @(posedge aclk) wk0 <= 1'b1;
    in_wake <= 1'b0;
    @(posedge aclk) aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wt("osc_reset", 1'b1, n);
    rd(A_PW, d, r);
    chk("wake_ctl", 0, d);
    complete_run();
  end
endmodule
